// *** verilog/bkm_pkg.sv ***
// Shared constants and types for the backup master handshake ends
package bkm_pkg;
   // ---------------------------------------------------------------
   // Message kinds carried on the management link
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      MSG_NONE          = 4'h0,
      MSG_ROUTE_REQ     = 4'h1,
      MSG_ROUTE_CNF     = 4'h2,
      MSG_ASSIGN_REQ    = 4'h3,
      MSG_ASSIGN_CNF    = 4'h4,
      MSG_DATA_IND      = 4'h5,
      MSG_RELEASE_REQ   = 4'h6,
      MSG_RELEASE_CNF   = 4'h7
   } msg_kind_t;

   // ---------------------------------------------------------------
   // Payload field positions
   // ---------------------------------------------------------------
   localparam int FORCED_BIT      = 0;
   localparam int ACCEPT_BIT      = 7;
   localparam int REJ_LSB         = 0;
   localparam int REJ_MSB         = 1;
   localparam logic [1:0] REJ_NONE = 2'h0;
   localparam logic [1:0] REJ_BUSY = 2'h1;
   localparam logic [7:0] SEL_VALID_MASK = 8'h3F;
   localparam logic [7:0] ZERO_OCTET = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ           = 50_000_000;
   localparam int TICK_MS_NS       = 1_000_000;
   localparam int CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
   localparam int TICK_CYCLES      = TICK_MS_NS / CLK_PERIOD_NS;
   localparam int CONFIRM_MS       = 100;
   localparam int RETRY_MS         = 300;
   localparam int HOLD_MS          = 1000;
   localparam int MS_W             = 11;
   localparam int TICK_W           = 16;
   localparam int SEQ_W            = 16;
   localparam int ID_W             = 8;
endpackage : bkm_pkg

// *** verilog/bkm_link_if.sv ***
// Management message link between master end and backup end
`timescale 1ns/100ps
`default_nettype none
interface bkm_link_if;
   import bkm_pkg::*;
   // Master to backup
   logic              m_valid;
   msg_kind_t         m_kind;
   logic [7:0]        m_octet0;
   logic [15:0]       m_word;
   logic [SEQ_W-1:0]  m_seq;
   // Backup to master
   logic              b_valid;
   msg_kind_t         b_kind;
   logic [7:0]        b_octet0;
   logic [15:0]       b_word;

   modport master (output m_valid, m_kind, m_octet0, m_word, m_seq,
                   input  b_valid, b_kind, b_octet0, b_word);
   modport backup (input  m_valid, m_kind, m_octet0, m_word, m_seq,
                   output b_valid, b_kind, b_octet0, b_word);
endinterface : bkm_link_if
`default_nettype wire

// *** verilog/ms_timer.sv ***
// Millisecond tick and millisecond window counter
`timescale 1ns/100ps
`default_nettype none
module ms_timer
   import bkm_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic              restart,
   output logic [MS_W-1:0]        ms_elapsed
);
   logic [TICK_W-1:0] tick_cnt_r;
   logic [MS_W-1:0]   ms_r;
   wire               tick_w = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

   // Counter saturates so a long idle never wraps into a false short window
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_r <= '0;
         ms_r       <= '0;
      end else if (clk_en) begin
         if (restart) begin
            tick_cnt_r <= '0;
            ms_r       <= '0;
         end else begin
            tick_cnt_r <= tick_w ? '0 : tick_cnt_r + 1'b1;
            if (tick_w && ms_r != '1) ms_r <= ms_r + 1'b1;
         end
      end
   end
   assign ms_elapsed = ms_r;
endmodule : ms_timer
`default_nettype wire

// *** verilog/bkm_master.sv ***
// Domain master end: routing return confirm and backup assign/data/release
// Contract
// - Routing confirm echoes request selection byte
// - Confirm carries last change sequence number
// - At most one backup; release first
// - Backup takes master role only after failure
// - Pick capable candidate with highest rank
// - Assign request bit0 forced, 7:1 zero
// - Candidate confirms assign within 100 ms
// - On reject, resend forced or other candidate
// - No confirm after 300 ms: resend allowed
// - Announce backup id in plan frame aux
// - Send periodic backup data indications
// - Backup confirms release within 100 ms
// - No release confirm 300 ms: resend allowed
// - Backup drops role 1 s after confirm
// - Request immediate ack on master messages; imm_ack_req stays low for routing confirm
// - Reject code 00 accepted, 01 busy
// - Accept bit 7 high, low only voluntary
// - Reserved bits sent zero, ignored on receive
// - Data indication is N management octets only
// - Data sequence starts zero, increments each send
// - Release messages carry empty payload
// - Selection byte bits 0..5 defined, others zero; master echoes a local route_req_sel unmasked
`timescale 1ns/100ps
`default_nettype none
module bkm_master
   import bkm_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   bkm_link_if.master             link,
   // Node side
   input  wire logic              route_req_valid,
   input  wire logic [7:0]        route_req_sel,
   input  wire logic [15:0]       last_change_sequence,
   input  wire logic              assign_start,
   input  wire logic              assign_forced,
   input  wire logic              cand_capable,
   input  wire logic              cand_top_rank,
   input  wire logic [ID_W-1:0]   cand_id,
   input  wire logic              data_send,
   input  wire logic [15:0]       data_word,
   input  wire logic              release_start,
   output logic                   busy,
   output logic                   backup_assigned,
   output logic [ID_W-1:0]        aux_backup_id,
   output logic                   aux_backup_valid,
   output logic                   imm_ack_req,
   output logic                   assign_rejected,
   output logic [1:0]             reject_code,
   output logic                   retry_allowed
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE     = 5'b00001,
      ST_ASSIGN_W = 5'b00010,
      ST_ACTIVE   = 5'b00100,
      ST_REL_W    = 5'b01000,
      ST_ROUTE    = 5'b10000
   } mst_state_t;

   mst_state_t        state_r, state_nxt;
   logic [ID_W-1:0]   bk_id_r;
   logic [SEQ_W-1:0]  seq_r;
   logic              valid_r;
   msg_kind_t         kind_r;
   logic [7:0]        oct0_r;
   logic [15:0]       word_r;
   logic [SEQ_W-1:0]  mseq_r;
   logic              rej_r;
   logic [1:0]        code_r;
   logic [7:0]        sel_r;
   logic [MS_W-1:0]   ms_elapsed;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire in_idle      = (state_r == ST_IDLE);
   wire in_active    = (state_r == ST_ACTIVE);
   wire cnf_seen     = link.b_valid && link.b_kind == MSG_ASSIGN_CNF;
   wire rel_seen     = link.b_valid && link.b_kind == MSG_RELEASE_CNF;
   wire route_seen   = link.b_valid && link.b_kind == MSG_ROUTE_REQ;
   wire cand_ok      = cand_capable && cand_top_rank;
   wire go_assign    = in_idle && assign_start && cand_ok;
   wire go_route     = in_idle && route_req_valid && !assign_start;
   wire take_route   = in_idle && !go_assign && (go_route || route_seen);
   wire [7:0] sel_in = go_route ? route_req_sel : link.b_octet0;
   wire cnf_accept   = link.b_octet0[ACCEPT_BIT];
   wire [1:0] cnf_code = link.b_octet0[REJ_MSB:REJ_LSB];
   wire go_data      = in_active && data_send;
   wire go_release   = in_active && release_start && !data_send;
   wire wait_state   = (state_r == ST_ASSIGN_W) || (state_r == ST_REL_W);
   wire timer_restart = go_assign || go_release || !wait_state;
   wire retry_w      = wait_state && (ms_elapsed >= MS_W'(RETRY_MS));
   wire resend_assign = (state_r == ST_ASSIGN_W) && retry_w && assign_start;
   wire resend_rel   = (state_r == ST_REL_W) && retry_w && release_start;

   ms_timer i_ms_timer (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .clk_en     (clk_en),
      .restart    (timer_restart || resend_assign || resend_rel),
      .ms_elapsed (ms_elapsed)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:     begin
            if (go_assign) state_nxt = ST_ASSIGN_W;
            else if (go_route || route_seen) state_nxt = ST_ROUTE;
         end
         ST_ASSIGN_W: begin
            if (cnf_seen) state_nxt = cnf_accept ? ST_ACTIVE : ST_IDLE;
         end
         ST_ACTIVE:   begin
            if (go_release) state_nxt = ST_REL_W;
         end
         ST_REL_W:    begin
            if (rel_seen) state_nxt = ST_IDLE;
         end
         ST_ROUTE:    state_nxt = ST_IDLE;
         default:     state_nxt = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bk_id_r <= '0;
         rej_r   <= 1'b0;
         code_r  <= REJ_NONE;
         sel_r   <= ZERO_OCTET;
      end else if (clk_en) begin
         if (go_assign) bk_id_r <= cand_id;
         if (take_route) sel_r <= sel_in;
         if (go_assign) rej_r <= 1'b0;
         if (state_r == ST_ASSIGN_W && cnf_seen) begin
            rej_r  <= !cnf_accept;
            code_r <= cnf_code;
         end
      end
   end

   // Sequence restarts at each assignment so the backup can spot a gap
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_r <= '0;
      end else if (clk_en) begin
         if (go_assign) seq_r <= '0;
         else if (go_data) seq_r <= seq_r + 1'b1;
      end
   end

   // Outgoing message register: one message per cycle, highest priority first
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         valid_r <= 1'b0;
         kind_r  <= MSG_NONE;
         oct0_r  <= ZERO_OCTET;
         word_r  <= '0;
         mseq_r  <= '0;
      end else if (clk_en) begin
         valid_r <= 1'b0;
         kind_r  <= MSG_NONE;
         oct0_r  <= ZERO_OCTET;
         word_r  <= '0;
         mseq_r  <= '0;
         if (go_assign || resend_assign) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_ASSIGN_REQ;
            oct0_r  <= {7'h00, assign_forced};
            word_r  <= data_word;
         end else if (state_r == ST_ROUTE) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_ROUTE_CNF;
            oct0_r  <= sel_r;
            word_r  <= last_change_sequence;
         end else if (go_data) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_DATA_IND;
            word_r  <= data_word;
            mseq_r  <= seq_r;
         end else if (go_release || resend_rel) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_RELEASE_REQ;
         end
      end
   end

   // Echoed byte belongs to whichever request opened the route state; local wins over link in one cycle
   assign link.m_valid  = valid_r;
   assign link.m_kind   = kind_r;
   assign link.m_octet0 = oct0_r;
   assign link.m_word   = word_r;
   assign link.m_seq    = mseq_r;

   assign busy             = !in_idle;
   assign backup_assigned  = in_active || (state_r == ST_REL_W);
   assign aux_backup_id    = bk_id_r;
   assign aux_backup_valid = backup_assigned;
   assign imm_ack_req      = valid_r && kind_r != MSG_ROUTE_CNF;
   assign assign_rejected  = rej_r;
   assign reject_code      = code_r;
   assign retry_allowed    = retry_w;
endmodule : bkm_master
`default_nettype wire

// *** verilog/bkm_backup.sv ***
// Backup candidate end: assign confirm, data intake, release confirm
`timescale 1ns/100ps
`default_nettype none
module bkm_backup
   import bkm_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   bkm_link_if.backup             link,
   input  wire logic              route_req,
   input  wire logic [7:0]        route_sel,
   input  wire logic              node_busy,
   input  wire logic              master_failed,
   output logic                   backup_role,
   output logic                   take_master,
   output logic                   data_valid,
   output logic [15:0]            data_word,
   output logic [SEQ_W-1:0]       data_seq,
   output logic [15:0]            route_seq,
   output logic                   route_valid
);
   typedef enum logic [2:0] {
      BK_IDLE = 3'b001,
      BK_ROLE = 3'b010,
      BK_HOLD = 3'b100
   } bk_state_t;

   bk_state_t   state_r, state_nxt;
   logic        valid_r;
   msg_kind_t   kind_r;
   logic [7:0]  oct0_r;
   logic [15:0] dword_r;
   logic [SEQ_W-1:0] dseq_r;
   logic        dval_r;
   logic [15:0] rseq_r;
   logic        rval_r;
   logic [MS_W-1:0] ms_elapsed;

   wire asg_seen  = link.m_valid && link.m_kind == MSG_ASSIGN_REQ;
   wire forced    = link.m_octet0[FORCED_BIT];
   wire accept    = forced || !node_busy;
   wire dat_seen  = link.m_valid && link.m_kind == MSG_DATA_IND;
   wire rel_seen  = link.m_valid && link.m_kind == MSG_RELEASE_REQ;
   wire rte_seen  = link.m_valid && link.m_kind == MSG_ROUTE_CNF;
   wire hold_done = (state_r == BK_HOLD) && (ms_elapsed >= MS_W'(HOLD_MS));

   ms_timer i_ms_timer (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .clk_en     (clk_en),
      .restart    (rel_seen || state_r != BK_HOLD),
      .ms_elapsed (ms_elapsed)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BK_IDLE: if (asg_seen && accept) state_nxt = BK_ROLE;
         BK_ROLE: if (rel_seen) state_nxt = BK_HOLD;
         BK_HOLD: begin
            if (asg_seen && accept) state_nxt = BK_ROLE;
            else if (hold_done) state_nxt = BK_IDLE;
         end
         default: state_nxt = BK_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) state_r <= BK_IDLE;
      else if (clk_en) state_r <= state_nxt;
   end

   // Confirms go out the cycle after the request, far inside the windows
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         valid_r <= 1'b0;
         kind_r  <= MSG_NONE;
         oct0_r  <= ZERO_OCTET;
      end else if (clk_en) begin
         valid_r <= 1'b0;
         kind_r  <= MSG_NONE;
         oct0_r  <= ZERO_OCTET;
         if (asg_seen) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_ASSIGN_CNF;
            oct0_r  <= {accept, 5'h00, accept ? REJ_NONE : REJ_BUSY};
         end else if (rel_seen && state_r != BK_IDLE) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_RELEASE_CNF;
         end else if (route_req) begin
            valid_r <= 1'b1;
            kind_r  <= MSG_ROUTE_REQ;
            oct0_r  <= route_sel & SEL_VALID_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dword_r <= '0;
         dseq_r  <= '0;
         dval_r  <= 1'b0;
         rseq_r  <= '0;
         rval_r  <= 1'b0;
      end else if (clk_en) begin
         dval_r <= dat_seen && state_r == BK_ROLE;
         rval_r <= rte_seen;
         if (dat_seen) dword_r <= link.m_word;
         if (dat_seen) dseq_r  <= link.m_seq;
         if (rte_seen) rseq_r  <= link.m_word;
      end
   end

   assign link.b_valid  = valid_r;
   assign link.b_kind   = kind_r;
   assign link.b_octet0 = oct0_r;
   assign link.b_word   = 16'h0000;
   assign backup_role   = state_r != BK_IDLE;
   assign take_master   = (state_r == BK_ROLE) && master_failed;
   assign data_valid    = dval_r;
   assign data_word     = dword_r;
   assign data_seq      = dseq_r;
   assign route_seq     = rseq_r;
   assign route_valid   = rval_r;
endmodule : bkm_backup
`default_nettype wire

// *** tb/bkm_sva.sv ***
// Link protocol checker for the backup master handshake
`timescale 1ns/100ps
`default_nettype none
module bkm_sva
   import bkm_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             m_valid,
   input  var  msg_kind_t        m_kind,
   input  wire logic [7:0]       m_octet0,
   input  wire logic [15:0]      m_word,
   input  wire logic [SEQ_W-1:0] m_seq,
   input  wire logic             b_valid,
   input  var  msg_kind_t        b_kind,
   input  wire logic [7:0]       b_octet0,
   input  wire logic [15:0]      b_word
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   // ---------------------------------------------------------------
   // Decode and tracking of the assignment state seen on the link
   // ---------------------------------------------------------------
   wire logic m_asg  = m_valid && m_kind == MSG_ASSIGN_REQ;
   wire logic m_data = m_valid && m_kind == MSG_DATA_IND;
   wire logic m_rel  = m_valid && m_kind == MSG_RELEASE_REQ;
   wire logic b_cnf  = b_valid && b_kind == MSG_ASSIGN_CNF;
   wire logic b_rel  = b_valid && b_kind == MSG_RELEASE_CNF;
   logic             assigned_r;
   logic [SEQ_W-1:0] seq_r;

   // Tracked from the link alone, so a master that miscounts cannot hide it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         assigned_r <= 1'h0;
         seq_r      <= '0;
      end else begin
         if (b_cnf && b_octet0[ACCEPT_BIT]) begin
            assigned_r <= 1'h1;
            seq_r      <= '0;
         end else if (m_data) begin
            seq_r <= seq_r + 1'h1;
         end
         if (b_rel) begin
            assigned_r <= 1'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_asg_rsvd;
      m_asg |-> m_octet0[7:1] == 7'h00;
   endproperty
   a_asg_rsvd: assert property (p_asg_rsvd) else $error("assign request reserved bits set");

   property p_asg_answer;
      m_asg |=> b_cnf;
   endproperty
   a_asg_answer: assert property (p_asg_answer) else $error("assign confirm missing");

   property p_rej_code;
      b_cnf |-> b_octet0[REJ_MSB:REJ_LSB] == (b_octet0[ACCEPT_BIT] ? REJ_NONE : REJ_BUSY);
   endproperty
   a_rej_code: assert property (p_rej_code) else $error("confirm code wrong");

   property p_forced_acc;
      b_cnf && $past(m_asg) && $past(m_octet0[FORCED_BIT]) |-> b_octet0[ACCEPT_BIT];
   endproperty
   a_forced_acc: assert property (p_forced_acc) else $error("forced assign rejected");

   property p_cnf_rsvd;
      b_cnf |-> b_octet0[6:2] == 5'h00;
   endproperty
   a_cnf_rsvd: assert property (p_cnf_rsvd) else $error("confirm reserved bits set");

   property p_rel_answer;
      m_rel |=> b_rel && b_word == 16'h0000 && b_octet0 == ZERO_OCTET;
   endproperty
   a_rel_answer: assert property (p_rel_answer) else $error("release confirm wrong");

   property p_rel_empty;
      m_rel |-> m_octet0 == ZERO_OCTET && m_word == 16'h0000;
   endproperty
   a_rel_empty: assert property (p_rel_empty) else $error("release request not empty");

   property p_one_backup;
      m_asg |-> !assigned_r;
   endproperty
   a_one_backup: assert property (p_one_backup) else $error("second backup assigned");

   property p_data_seq;
      m_data |-> assigned_r && m_seq == seq_r;
   endproperty
   a_data_seq: assert property (p_data_seq) else $error("data sequence wrong");

   c_accept: cover property (b_cnf && b_octet0[ACCEPT_BIT]);
   c_reject: cover property (b_cnf && !b_octet0[ACCEPT_BIT]);
   c_data:   cover property (m_data ##1 !m_data [*2] ##1 m_data);
   c_rel:    cover property (m_rel ##1 b_rel);
endmodule : bkm_sva
`default_nettype wire

// *** tb/backup_master_handshake_tb_top.sv ***
// Self-checking bench joining master and backup ends over the link
`timescale 1ns/100ps
`default_nettype none
module backup_master_handshake_tb_top
   import bkm_pkg::*;
;
   logic sys_clk, resetn, clk_en, route_req_valid, assign_start, assign_forced, cand_capable;
   logic cand_top_rank, data_send, release_start, route_req, node_busy, master_failed;
   logic busy, backup_assigned, aux_backup_valid, imm_ack_req, assign_rejected, backup_role, take_master;
   logic retry_allowed, data_valid, route_valid;
   logic [7:0]       route_req_sel, route_sel;
   logic [ID_W-1:0]  cand_id, aux_backup_id;
   logic [15:0]      last_change_sequence, data_word, b_data_word, route_seq;
   logic [1:0]       reject_code;
   logic [SEQ_W-1:0] data_seq;
   int               err_total, n_tests;

   bkm_link_if lnk();

   bkm_master i_bkm_master (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .link(lnk),
      .route_req_valid(route_req_valid), .route_req_sel(route_req_sel),
      .last_change_sequence(last_change_sequence), .assign_start(assign_start),
      .assign_forced(assign_forced), .cand_capable(cand_capable), .cand_top_rank(cand_top_rank),
      .cand_id(cand_id), .data_send(data_send), .data_word(data_word), .release_start(release_start),
      .busy(busy), .backup_assigned(backup_assigned), .aux_backup_id(aux_backup_id),
      .aux_backup_valid(aux_backup_valid), .imm_ack_req(imm_ack_req), .assign_rejected(assign_rejected),
      .reject_code(reject_code), .retry_allowed(retry_allowed));

   bkm_backup i_bkm_backup (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .link(lnk),
      .route_req(route_req), .route_sel(route_sel), .node_busy(node_busy),
      .master_failed(master_failed), .backup_role(backup_role), .take_master(take_master),
      .data_valid(data_valid), .data_word(b_data_word), .data_seq(data_seq), .route_seq(route_seq),
      .route_valid(route_valid));

   bkm_sva i_bkm_sva (.sys_clk(sys_clk), .resetn(resetn), .m_valid(lnk.m_valid), .m_kind(lnk.m_kind),
      .m_octet0(lnk.m_octet0), .m_word(lnk.m_word), .m_seq(lnk.m_seq), .b_valid(lnk.b_valid),
      .b_kind(lnk.b_kind), .b_octet0(lnk.b_octet0), .b_word(lnk.b_word));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic conclude();
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // Waits a bounded time for a message; returns at the negedge it is seen
   task automatic wait_link(input logic side_b, input msg_kind_t k, input logic want);
      logic hit;
      hit = 1'h0;
      for (int i = 0; i < 12 && !hit; i++) begin
         @(negedge sys_clk);
         hit = side_b ? (lnk.b_valid === 1'h1 && lnk.b_kind === k) : (lnk.m_valid === 1'h1 && lnk.m_kind === k);
      end
      chk({15'h0000, hit}, {15'h0000, want});
      if (want && !hit) conclude();
      else if (hit && !side_b && k != MSG_ROUTE_CNF) chk({15'h0000, imm_ack_req}, 16'h0001);
   endtask : wait_link

   task automatic assign_once(input logic [7:0] req_octet, input logic [7:0] cnf_octet);
      assign_start <= 1'h1;
      cyc(1);
      assign_start <= 1'h0;
      wait_link(1'h0, MSG_ASSIGN_REQ, 1'h1);
      chk({8'h00, lnk.m_octet0}, {8'h00, req_octet});
      chk({15'h0000, retry_allowed}, 16'h0000);
      wait_link(1'h1, MSG_ASSIGN_CNF, 1'h1);
      chk({8'h00, lnk.b_octet0}, {8'h00, cnf_octet});
      cyc(2);
   endtask : assign_once

   task automatic data_burst(input int n);
      for (int i = 0; i < n; i++) begin
         data_word <= 16'h1000 + 16'(i);
         data_send <= 1'h1;
         cyc(1);
         data_send <= 1'h0;
         wait_link(1'h0, MSG_DATA_IND, 1'h1);
         chk(lnk.m_seq, SEQ_W'(i));
         chk(lnk.m_word, 16'h1000 + 16'(i));
         @(negedge sys_clk);
         chk({15'h0000, data_valid}, 16'h0001);
         chk(data_seq, SEQ_W'(i));
         chk(b_data_word, 16'h1000 + 16'(i));
         cyc(1);
      end
   endtask : data_burst

   // ---------------------------------------------------------------
   // Clock and main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      {resetn, route_req_valid, assign_start, assign_forced, data_send, release_start} = 6'h00;
      {route_req, master_failed} = 2'h0;
      {clk_en, cand_capable, node_busy, cand_top_rank} = 4'hE;
      {route_req_sel, route_sel, cand_id} = 24'h2DEB5C;
      last_change_sequence = 16'hA55A;
      data_word = 16'h0000;
      err_total = 0;
      n_tests = 0;
      cyc(4);
      resetn <= 1'h1;
      cyc(1);
      // Routing confirm asked by the local node
      route_req_valid <= 1'h1;
      cyc(1);
      route_req_valid <= 1'h0;
      wait_link(1'h0, MSG_ROUTE_CNF, 1'h1);
      chk({8'h00, lnk.m_octet0}, 16'h002D);
      chk(lnk.m_word, 16'hA55A);
      // Routing request arriving over the link from the far node
      cyc(2);
      route_req <= 1'h1;
      cyc(1);
      route_req <= 1'h0;
      wait_link(1'h0, MSG_ROUTE_CNF, 1'h1);
      chk({8'h00, lnk.m_octet0}, 16'h002B);
      cyc(1);
      @(negedge sys_clk);
      chk({15'h0000, route_valid}, 16'h0001);
      chk(route_seq, 16'hA55A);
      cyc(1);
      // Candidate without top rank is never asked
      assign_start <= 1'h1;
      cyc(1);
      assign_start <= 1'h0;
      wait_link(1'h0, MSG_ASSIGN_REQ, 1'h0);
      cyc(1);
      cand_top_rank <= 1'h1;
      // Voluntary request to a busy node is rejected
      assign_once(8'h00, 8'h01);
      chk({15'h0000, assign_rejected}, 16'h0001);
      chk({14'h0000, reject_code}, {14'h0000, REJ_BUSY});
      chk({15'h0000, backup_assigned}, 16'h0000);
      // Forced request to the same node is accepted
      assign_forced <= 1'h1;
      assign_once(8'h01, 8'h80);
      chk({15'h0000, backup_assigned}, 16'h0001);
      chk({8'h00, aux_backup_id}, 16'h005C);
      chk({15'h0000, aux_backup_valid}, 16'h0001);
      chk({15'h0000, take_master}, 16'h0000);
      // No second assignment while one backup stands
      assign_start <= 1'h1;
      cyc(1);
      assign_start <= 1'h0;
      wait_link(1'h0, MSG_ASSIGN_REQ, 1'h0);
      // Clock enable low freezes the master, so no data goes out
      cyc(1);
      clk_en <= 1'h0;
      data_send <= 1'h1;
      cyc(1);
      data_send <= 1'h0;
      wait_link(1'h0, MSG_DATA_IND, 1'h0);
      cyc(1);
      clk_en <= 1'h1;
      data_burst(3);
      // Master failure lets the backup take over
      master_failed <= 1'h1;
      @(negedge sys_clk);
      chk({15'h0000, take_master}, 16'h0001);
      cyc(1);
      master_failed <= 1'h0;
      // Release with empty payloads both ways
      release_start <= 1'h1;
      cyc(1);
      release_start <= 1'h0;
      wait_link(1'h0, MSG_RELEASE_REQ, 1'h1);
      chk({8'h00, lnk.m_octet0}, 16'h0000);
      chk(lnk.m_word, 16'h0000);
      wait_link(1'h1, MSG_RELEASE_CNF, 1'h1);
      chk(lnk.b_word, 16'h0000);
      cyc(2);
      chk({15'h0000, backup_assigned}, 16'h0000);
      chk({15'h0000, busy}, 16'h0000);
      chk({15'h0000, backup_role}, 16'h0001);
      // Fresh voluntary assignment restarts the data sequence
      node_busy <= 1'h0;
      assign_forced <= 1'h0;
      assign_once(8'h00, 8'h80);
      data_burst(2);
      conclude();
   end
endmodule : backup_master_handshake_tb_top
`default_nettype wire
